/* File: common/rcs_consts.svh */
// register offsets, command codes, field positions and counts of the command sequencer
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_A_CMD 8'h00
`define RCS_A_FRAME 8'h04
`define RCS_A_MODE 8'h08
`define RCS_A_SELF 8'h0c
`define RCS_A_CRC 8'h10
`define RCS_A_FIFO 8'h14
`define RCS_A_LEVEL 8'h18
`define RCS_A_STAT 8'h1c
`define RCS_OP_IDLE 4'h0
`define RCS_OP_MEM 4'h1
`define RCS_OP_RNG 4'h2
`define RCS_OP_CRC 4'h3
`define RCS_OP_TX 4'h4
`define RCS_OP_KEEP 4'h7
`define RCS_OP_RX 4'h8
`define RCS_OP_TRX 4'hc
`define RCS_OP_AUTH 4'he
`define RCS_OP_SRST 4'hf
`define RCS_SLEEP_POS 4
`define RCS_LAUNCH_POS 7
`define RCS_SELF_ON 4'h9
`define RCS_BUF_LEN 25
`define RCS_RNG_LEN 10
`define RCS_AUTH_LEN 12
`define RCS_TEST_LEN 8
`define RCS_FIFO_DEPTH 64
`define RCS_PRESET0 16'h0000
`define RCS_PRESET1 16'h5555
`define RCS_PRESET2 16'haaaa
`define RCS_PRESET3 16'hffff
`define RCS_CRC_POLY 16'h1021
`define RCS_RNG_SEED 16'h0001
`define RCS_RNG_TAPS 16'hb400
`endif

/* File: common/rcs_pkg.sv */
// types shared by the command sequencer files
package rcs_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_MEM_IN, S_MEM_OUT, S_RNG, S_CRC, S_TEST, S_TX,
    S_TRX_WAIT, S_TRX_TX, S_TRX_RX, S_RX, S_AUTH_ARGS, S_AUTH_RUN
  } rcs_state_t;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rcs_apb_req_t;
  // outbound byte toward transmitter or authentication engine
  typedef struct packed {
    logic auth;
    logic [7:0] data;
  } rcs_strm_t;
endpackage

/* File: hdl/rcs_crc.sv */
// byte-wide crc coprocessor with preset load
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_crc (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control and data
  input wire logic init_i,
  input wire logic [15:0] preset_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  // running checksum
  output logic [15:0] crc_o
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // one byte folded in per cycle, msb first
  always_comb begin
    logic [15:0] c;
    c = crc_reg;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data_i[i]) ? ((c << 1) ^ `RCS_CRC_POLY) : (c << 1);
    end
    crc_next = c;
  end

  // init wins over a byte in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      crc_reg <= 16'h0000;
    end else if (init_i) begin
      crc_reg <= preset_i;
    end else if (en_i) begin
      crc_reg <= crc_next;
    end
  end

  assign crc_o = crc_reg;
endmodule

/* File: hdl/rcs_rng.sv */
// free-running lfsr used as random byte source
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_rng (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // current random byte
  output logic [7:0] byte_o
);
  logic [15:0] lfsr_reg;

  // runs every cycle so the value depends on when the command lands
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lfsr_reg <= `RCS_RNG_SEED;
    end else begin
      lfsr_reg <= (lfsr_reg >> 1) ^ (lfsr_reg[0] ? `RCS_RNG_TAPS : 16'h0000);
    end
  end

  assign byte_o = lfsr_reg[7:0];
endmodule

/* File: hdl/rcs_top.sv */
// command sequencer of the reader frontend with apb registers and fifo
`timescale 1ns/1ps
`include "rcs_consts.svh"
// Operation
// - command code written selects the operation
// - arguments and data pass through the fifo
// - stream ops start at once; transceive waits launch
// - fixed-argument op waits for all argument bytes
// - starting an op never clears the fifo
// - new command code aborts running operation, except 0111 and reserved codes
// - code 0000 idles and cancels
// - code 0001 moves 25 fifo bytes to buffer
// - empty fifo: buffer copied back into fifo
// - buffer survives hard power-down reset
// - buffer transfer ends itself, back to idle
// - code 0010 writes 10 random bytes to buffer
// - random generation ends itself, back to idle
// - code 0011 feeds fifo bytes into crc
// - empty fifo never ends crc computation
// - crc preset loaded when crc op starts
// - self-check value turns crc op into self test
// - code 0100 transmits fifo contents
// - code 0111 keeps running op, updates sleep
// - 1000 receives; 1100 transmits then receives
// - code 1110 runs card authentication
// - software reset clears registers, keeps buffer
module rcs_top #(
  parameter int DEPTH = `RCS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire rcs_pkg::rcs_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // outbound byte stream
  output rcs_pkg::rcs_strm_t out_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  // transmitter and receiver
  output logic tx_start_o,
  output logic rx_on_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_end_i,
  // authentication engine
  output logic auth_start_o,
  input wire logic auth_done_i,
  // power control
  output logic sleep_o
);
  import rcs_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // elaboration check on the fifo shape
  if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two from 2 to 256");
  end

  // soft reset acts in the cycle after its code is written
  logic srst_reg;
  wire rst = !rstn_i || srst_reg;

  // apb phase decode
  logic pready_reg;
  wire setup = apb_i.psel && !apb_i.penable;
  wire acc = apb_i.psel && apb_i.penable && pready_reg;
  wire wr = acc && apb_i.pwrite;
  wire rd = acc && !apb_i.pwrite;
  wire a_cmd = apb_i.paddr == `RCS_A_CMD;
  wire a_frame = apb_i.paddr == `RCS_A_FRAME;
  wire a_mode = apb_i.paddr == `RCS_A_MODE;
  wire a_self = apb_i.paddr == `RCS_A_SELF;
  wire a_crc = apb_i.paddr == `RCS_A_CRC;
  wire a_fifo = apb_i.paddr == `RCS_A_FIFO;
  wire a_level = apb_i.paddr == `RCS_A_LEVEL;
  wire a_stat = apb_i.paddr == `RCS_A_STAT;
  wire mapped = a_cmd | a_frame | a_mode | a_self | a_crc | a_fifo | a_level | a_stat;

  // command decode; unknown and reserved codes start nothing
  wire [3:0] wcode = apb_i.pwdata[3:0];
  wire cmd_wr = wr && a_cmd;
  wire code_ok = (wcode == `RCS_OP_IDLE) | (wcode == `RCS_OP_MEM) | (wcode == `RCS_OP_RNG)
    | (wcode == `RCS_OP_CRC) | (wcode == `RCS_OP_TX) | (wcode == `RCS_OP_RX)
    | (wcode == `RCS_OP_TRX) | (wcode == `RCS_OP_AUTH) | (wcode == `RCS_OP_SRST);
  wire cmd_go = cmd_wr && code_ok;

  // software-visible control
  logic sleep_reg;
  logic [1:0] mode_reg;
  logic [3:0] self_reg;
  logic launch_reg;
  logic launch_use;
  wire launch_set = wr && a_frame && apb_i.pwdata[`RCS_LAUNCH_POS];

  // fifo storage and pointers
  logic [7:0] fifo_mem [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  wire fifo_empty = cnt_reg == '0;
  wire fifo_full = cnt_reg == CW'(DEPTH);
  wire [7:0] fifo_head = fifo_mem[rp_reg];

  // host and device share one push and one pop port, host first
  logic dpush_req;
  logic dpop_req;
  logic [7:0] dpush_data;
  wire hpush = wr && a_fifo && !fifo_full;
  wire hpop = rd && a_fifo && !fifo_empty;
  wire dpush = dpush_req && !hpush && !fifo_full;
  wire dpop = dpop_req && !hpop && !fifo_empty;
  wire push = hpush || dpush;
  wire pop = hpop || dpop;
  wire [7:0] push_data = hpush ? apb_i.pwdata[7:0] : dpush_data;

  // sequencer
  rcs_state_t state_reg;
  rcs_state_t state_next;
  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic [7:0] buf_mem [`RCS_BUF_LEN];
  logic buf_we;
  logic [7:0] buf_wd;
  logic crc_init;
  logic crc_en;
  logic [7:0] crc_din;
  logic [15:0] crc_val;
  logic [7:0] rng_byte;
  logic load_out;
  logic start_tx;
  logic start_auth;
  rcs_strm_t out_reg;
  logic out_valid_reg;
  logic tx_start_reg;
  logic rx_on_reg;
  logic auth_start_reg;

  // crc preset select
  wire [15:0] preset_val = (mode_reg == 2'd0) ? `RCS_PRESET0 :
                           (mode_reg == 2'd1) ? `RCS_PRESET1 :
                           (mode_reg == 2'd2) ? `RCS_PRESET2 : `RCS_PRESET3;
  wire self_on = self_reg == `RCS_SELF_ON;
  wire rx_state = (state_next == S_RX) || (state_next == S_TRX_RX);

  // running operation shown back in the command field
  function automatic logic [3:0] op_code(rcs_state_t s);
    case (s)
      S_MEM_IN, S_MEM_OUT: op_code = `RCS_OP_MEM;
      S_RNG: op_code = `RCS_OP_RNG;
      S_CRC, S_TEST: op_code = `RCS_OP_CRC;
      S_TX: op_code = `RCS_OP_TX;
      S_RX: op_code = `RCS_OP_RX;
      S_TRX_WAIT, S_TRX_TX, S_TRX_RX: op_code = `RCS_OP_TRX;
      S_AUTH_ARGS, S_AUTH_RUN: op_code = `RCS_OP_AUTH;
      default: op_code = `RCS_OP_IDLE;
    endcase
  endfunction

  // state machine next-state and strobes
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    dpush_req = 1'b0;
    dpush_data = 8'h00;
    dpop_req = 1'b0;
    buf_we = 1'b0;
    buf_wd = 8'h00;
    crc_init = 1'b0;
    crc_en = 1'b0;
    crc_din = 8'h00;
    load_out = 1'b0;
    start_tx = 1'b0;
    start_auth = 1'b0;
    launch_use = 1'b0;
    case (state_reg)
      S_MEM_IN: begin
        // waits for each byte while the fifo is short
        dpop_req = 1'b1;
        if (dpop) begin
          buf_we = 1'b1;
          buf_wd = fifo_head;
          idx_next = idx_reg + 5'd1;
          if (idx_reg == 5'(`RCS_BUF_LEN - 1)) state_next = S_IDLE;
        end
      end
      S_MEM_OUT: begin
        dpush_req = 1'b1;
        dpush_data = buf_mem[idx_reg];
        if (dpush) begin
          idx_next = idx_reg + 5'd1;
          if (idx_reg == 5'(`RCS_BUF_LEN - 1)) state_next = S_IDLE;
        end
      end
      S_RNG: begin
        buf_we = 1'b1;
        buf_wd = rng_byte;
        idx_next = idx_reg + 5'd1;
        if (idx_reg == 5'(`RCS_RNG_LEN - 1)) state_next = S_IDLE;
      end
      S_CRC: begin
        // no end on empty fifo; only a new command leaves
        dpop_req = 1'b1;
        crc_en = dpop;
        crc_din = fifo_head;
      end
      S_TEST: begin
        // self test: checksum of a counting pattern, one result byte each
        dpush_req = 1'b1;
        dpush_data = crc_val[7:0];
        crc_din = {3'h0, idx_reg};
        if (dpush) begin
          crc_en = 1'b1;
          idx_next = idx_reg + 5'd1;
          if (idx_reg == 5'(`RCS_TEST_LEN - 1)) state_next = S_IDLE;
        end
      end
      S_TX, S_TRX_TX: begin
        // one byte in flight; ends when the fifo runs dry
        dpop_req = !out_valid_reg;
        load_out = dpop;
        if (fifo_empty && !out_valid_reg) begin
          state_next = (state_reg == S_TX) ? S_IDLE : S_TRX_RX;
        end
      end
      S_TRX_WAIT: begin
        if (launch_reg) begin
          launch_use = 1'b1;
          start_tx = 1'b1;
          state_next = S_TRX_TX;
        end
      end
      S_RX, S_TRX_RX: begin
        // bytes lost when the fifo is full
        dpush_req = rx_valid_i;
        dpush_data = rx_data_i;
        if (rx_end_i) state_next = (state_reg == S_RX) ? S_IDLE : S_TRX_WAIT;
      end
      S_AUTH_ARGS: begin
        dpop_req = !out_valid_reg && (idx_reg < 5'(`RCS_AUTH_LEN));
        load_out = dpop;
        if (dpop) idx_next = idx_reg + 5'd1;
        if (idx_reg == 5'(`RCS_AUTH_LEN) && !out_valid_reg) begin
          start_auth = 1'b1;
          state_next = S_AUTH_RUN;
        end
      end
      S_AUTH_RUN: begin
        if (auth_done_i) state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
    // a new code aborts whatever ran, fifo left as it is
    if (cmd_go) begin
      idx_next = 5'd0;
      dpush_req = 1'b0;
      dpop_req = 1'b0;
      buf_we = 1'b0;
      load_out = 1'b0;
      crc_en = 1'b0;
      start_auth = 1'b0;
      launch_use = 1'b0;
      start_tx = 1'b0;
      case (wcode)
        `RCS_OP_MEM: state_next = fifo_empty ? S_MEM_OUT : S_MEM_IN;
        `RCS_OP_RNG: state_next = S_RNG;
        `RCS_OP_CRC: begin
          crc_init = 1'b1;
          state_next = self_on ? S_TEST : S_CRC;
        end
        `RCS_OP_TX: begin
          start_tx = 1'b1;
          state_next = S_TX;
        end
        `RCS_OP_RX: state_next = S_RX;
        `RCS_OP_TRX: state_next = S_TRX_WAIT;
        `RCS_OP_AUTH: state_next = S_AUTH_ARGS;
        default: state_next = S_IDLE;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst) begin
      state_reg <= S_IDLE;
      idx_reg <= 5'd0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // soft reset pulse, cleared only by itself or the pin reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= cmd_go && (wcode == `RCS_OP_SRST);
    end
  end

  // internal buffer: no reset at all, so it survives every reset
  always_ff @(posedge clk_i) begin
    if (buf_we) buf_mem[idx_reg] <= buf_wd;
  end

  // fifo storage
  always_ff @(posedge clk_i) begin
    if (push) fifo_mem[wp_reg] <= push_data;
  end

  // fifo pointers; never cleared by a command start
  always_ff @(posedge clk_i) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_reg + PW'(push);
      rp_reg <= rp_reg + PW'(pop);
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end

  // control registers; launch set beats its own clear
  always_ff @(posedge clk_i) begin
    if (rst) begin
      sleep_reg <= 1'b0;
      mode_reg <= 2'd0;
      self_reg <= 4'h0;
      launch_reg <= 1'b0;
    end else begin
      if (cmd_wr) sleep_reg <= apb_i.pwdata[`RCS_SLEEP_POS];
      if (wr && a_mode) mode_reg <= apb_i.pwdata[1:0];
      if (wr && a_self) self_reg <= apb_i.pwdata[3:0];
      launch_reg <= launch_set || (launch_reg && !launch_use);
    end
  end

  // outbound stream and start strobes
  always_ff @(posedge clk_i) begin
    if (rst) begin
      out_reg <= '0;
      out_valid_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      auth_start_reg <= 1'b0;
    end else begin
      if (load_out) begin
        out_reg <= '{auth: (state_reg == S_AUTH_ARGS), data: fifo_head};
        out_valid_reg <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_reg <= 1'b0;
      end
      tx_start_reg <= start_tx;
      rx_on_reg <= rx_state;
      auth_start_reg <= start_auth;
    end
  end

  // read data mux
  wire [31:0] rd_mux =
    a_cmd ? {27'h0, sleep_reg, op_code(state_reg)} :
    a_frame ? {24'h0, launch_reg, 7'h00} :
    a_mode ? {30'h0, mode_reg} :
    a_self ? {28'h0, self_reg} :
    a_crc ? {16'h0, crc_val} :
    a_fifo ? {24'h0, fifo_empty ? 8'h00 : fifo_head} :
    a_level ? {{(32 - CW){1'b0}}, cnt_reg} :
    a_stat ? {28'h0, state_reg} : 32'h0;

  // apb answer: ready in the first access cycle
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  always_ff @(posedge clk_i) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) prdata_reg <= rd_mux;
    end
  end

  // crc coprocessor
  rcs_crc u_crc (
    .clk_i(clk_i),
    .rstn_i(!rst),
    .init_i(crc_init),
    .preset_i(preset_val),
    .en_i(crc_en),
    .data_i(crc_din),
    .crc_o(crc_val)
  );

  // random source
  rcs_rng u_rng (
    .clk_i(clk_i),
    .rstn_i(!rst),
    .byte_o(rng_byte)
  );

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign out_o = out_reg;
  assign out_valid_o = out_valid_reg;
  assign tx_start_o = tx_start_reg;
  assign rx_on_o = rx_on_reg;
  assign auth_start_o = auth_start_reg;
  assign sleep_o = sleep_reg;

  // checks
  property p_idle;
    @(posedge clk_i) disable iff (rst) cmd_go && wcode == `RCS_OP_IDLE |=> state_reg == S_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle code did not idle");
  property p_abort;
    @(posedge clk_i) disable iff (rst) cmd_go |=> idx_reg == 5'd0 && !auth_start_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not restart");
  property p_mem_dir;
    @(posedge clk_i) disable iff (rst)
      cmd_go && wcode == `RCS_OP_MEM |=> state_reg == ($past(fifo_empty) ? S_MEM_OUT : S_MEM_IN);
  endproperty
  a_mem_dir: assert property (p_mem_dir) else $error("wrong buffer direction");
  property p_mem_end;
    @(posedge clk_i) disable iff (rst)
      state_reg == S_MEM_IN && dpop && idx_reg == 5'd24 && !cmd_go |=> state_reg == S_IDLE;
  endproperty
  a_mem_end: assert property (p_mem_end) else $error("buffer store did not end");
  property p_auth_wait;
    @(posedge clk_i) disable iff (rst) state_reg == S_AUTH_ARGS && idx_reg < 5'd12 |=> !auth_start_o;
  endproperty
  a_auth_wait: assert property (p_auth_wait) else $error("auth started early");
  property p_launch;
    @(posedge clk_i) disable iff (rst)
      state_reg == S_TRX_WAIT && !launch_reg && !cmd_go |=> state_reg == S_TRX_WAIT && !tx_start_o;
  endproperty
  a_launch: assert property (p_launch) else $error("transmit without launch");
  property p_keep;
    @(posedge clk_i) disable iff (rst)
      cmd_wr && wcode == `RCS_OP_KEEP && state_reg == S_CRC |=> state_reg == S_CRC;
  endproperty
  a_keep: assert property (p_keep) else $error("keep code changed the op");
  property p_preset;
    @(posedge clk_i) disable iff (rst)
      cmd_go && wcode == `RCS_OP_CRC |=> crc_val == $past(preset_val);
  endproperty
  a_preset: assert property (p_preset) else $error("crc preset not loaded");
  property p_fifo_kept;
    @(posedge clk_i) disable iff (rst) cmd_go |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_fifo_kept: assert property (p_fifo_kept) else $error("fifo touched at start");
  property p_rng_end;
    @(posedge clk_i) disable iff (rst) $rose(state_reg == S_RNG) |-> ##[1:10] state_reg != S_RNG;
  endproperty
  a_rng_end: assert property (p_rng_end) else $error("random op did not end");
  property p_crc_stay;
    @(posedge clk_i) disable iff (rst) state_reg == S_CRC && !cmd_go |=> state_reg == S_CRC;
  endproperty
  a_crc_stay: assert property (p_crc_stay) else $error("crc op ended itself");
endmodule

/* File: tb/rcs_far_model.sv */
// far-side model: stream sink, receiver and authentication engine
`timescale 1ns/1ps
module rcs_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // outbound byte stream
  input wire rcs_pkg::rcs_strm_t out_i,
  input wire logic out_valid_i,
  output logic out_ready_o,
  // receiver side
  input wire logic rx_on_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  // authentication engine
  input wire logic auth_start_i,
  output logic auth_done_o
);
  import rcs_pkg::*;
  logic [7:0] got[$]; // accepted bytes in arrival order
  int n_auth; // accepted bytes flagged for the auth engine
  logic [15:0] lfsr; // stall pattern, mixes prompt and slow acceptance
  int rx_cnt; // cycles spent in a receive phase
  int auth_cnt; // cycles since authentication start
  // sink with stalls; a byte counts only on valid and ready together
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      lfsr <= 16'hace1;
      out_ready_o <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      out_ready_o <= lfsr[0] | lfsr[3];
      if (out_valid_i && out_ready_o) begin
        got.push_back(out_i.data);
        if (out_i.auth) n_auth++;
      end
    end
  end
  // receiver: three bytes then frame end; idle data keeps toggling
  always @(posedge clk_i) begin
    rx_valid_o <= 1'b0;
    rx_end_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    if (!rstn_i || !rx_on_i) rx_cnt <= 0;
    else begin
      rx_cnt <= rx_cnt + 1;
      if (rx_cnt == 4 || rx_cnt == 8 || rx_cnt == 12) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= 8'h30 + 8'(rx_cnt);
      end
      if (rx_cnt == 16) rx_end_o <= 1'b1;
    end
  end
  // authentication engine answers six cycles after its start pulse
  always @(posedge clk_i) begin
    auth_done_o <= 1'b0;
    if (!rstn_i) auth_cnt <= 0;
    else if (auth_start_i) auth_cnt <= 1;
    else if (auth_cnt == 6) begin
      auth_done_o <= 1'b1;
      auth_cnt <= 0;
    end else if (auth_cnt > 0) auth_cnt <= auth_cnt + 1;
  end
  initial rx_data_o = 8'h00;
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the command sequencer
`timescale 1ns/1ps
`include "rcs_consts.svh"
module testbench;
  import rcs_pkg::*;
  logic clk_i; // system clock
  logic rstn_i; // synchronous reset, active low
  rcs_apb_req_t apb; // bus request driven by the bench
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  rcs_strm_t out_o;
  logic out_valid_o, out_ready, tx_start_o, rx_on_o, rx_valid, rx_end;
  logic [7:0] rx_data;
  logic auth_start_o, auth_done, sleep_o;
  int n_fail, n_tests, cyc, n_txs; // counters, timeout clock, transmit starts
  logic [31:0] seed, rd; // random state and last read data
  logic err; // last slave error
  logic [7:0] exp_q[$]; // bytes stored in the buffer
  logic [15:0] crc; // expected checksum
  int diff; // random bytes that differ from the stored ones
  rcs_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .apb_i(apb), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .out_o(out_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready), .tx_start_o(tx_start_o), .rx_on_o(rx_on_o),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_end_i(rx_end),
    .auth_start_o(auth_start_o), .auth_done_i(auth_done), .sleep_o(sleep_o));
  rcs_far_model i_far (.clk_i(clk_i), .rstn_i(rstn_i), .out_i(out_o),
    .out_valid_i(out_valid_o), .out_ready_o(out_ready), .rx_on_i(rx_on_o),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_end_o(rx_end),
    .auth_start_i(auth_start_o), .auth_done_o(auth_done));
  // xorshift source, fixed start for repeatable runs
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // one byte folded msb first into the checksum
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) x = x[15] ? {x[14:0], 1'b0} ^ `RCS_CRC_POLY : {x[14:0], 1'b0};
    return x;
  endfunction
  // start value chosen by the preset field
  function automatic logic [15:0] preset(input int p);
    case (p)
      0: return `RCS_PRESET0;
      1: return `RCS_PRESET1;
      2: return `RCS_PRESET2;
      default: return `RCS_PRESET3;
    endcase
  endfunction
  // single comparison point
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // apb transfer: setup, then access held until pready at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    apb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // poll the running code until idle, bounded
  task automatic wait_idle();
    for (int i = 0; i < 200; i++) begin
      rdr(`RCS_A_CMD);
      if (rd[3:0] === `RCS_OP_IDLE) return;
    end
    chk("idle wait", rd[3:0], `RCS_OP_IDLE);
  endtask
  // drain the three received bytes from the fifo
  task automatic drain_rx();
    rdr(`RCS_A_LEVEL);
    chk("rx level", rd, 32'h3);
    for (int i = 1; i <= 3; i++) begin
      rdr(`RCS_A_FIFO);
      chk("rx byte", rd, 32'h30 + 4 * i);
    end
  endtask
  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // hang guard well above the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (tx_start_o === 1'b1) n_txs <= n_txs + 1;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    apb = '0;
    rstn_i = 1'b0;
    seed = 32'h5f63;
    cyc = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdr(`RCS_A_CMD);
    chk("code after reset", rd, 32'h0);
    rdr(8'h40);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    test_end("reset");
    // preload 25 bytes, then store them
    for (int i = 0; i < `RCS_BUF_LEN; i++) begin
      exp_q.push_back(xs());
      wr(`RCS_A_FIFO, {24'h0, exp_q[i]});
    end
    wr(`RCS_A_CMD, `RCS_OP_MEM);
    wait_idle();
    rdr(`RCS_A_LEVEL);
    chk("level after store", rd, 32'h0);
    wr(`RCS_A_CMD, `RCS_OP_RNG);
    wait_idle();
    // soft reset clears setup, then a hard reset; buffer must survive both
    wr(`RCS_A_MODE, 32'h3);
    wr(`RCS_A_CMD, `RCS_OP_SRST);
    wait_idle();
    rdr(`RCS_A_MODE);
    chk("mode after soft reset", rd, 32'h0);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    wr(`RCS_A_CMD, `RCS_OP_MEM);
    wait_idle();
    rdr(`RCS_A_LEVEL);
    chk("recall level", rd, 32'd25);
    diff = 0;
    for (int i = 0; i < `RCS_BUF_LEN; i++) begin
      rdr(`RCS_A_FIFO);
      if (i >= `RCS_RNG_LEN) chk("recalled byte", rd, {24'h0, exp_q[i]});
      else if (rd[7:0] !== exp_q[i]) diff++;
    end
    chk("random overwrite", diff > 0, 1'b1);
    test_end("buffer");
    // crc over every preset, with bytes arriving after the fifo ran dry
    for (int p = 0; p < 4; p++) begin
      crc = preset(p);
      wr(`RCS_A_MODE, p);
      wr(`RCS_A_CMD, `RCS_OP_CRC);
      for (int i = 0; i < 4; i++) begin
        exp_q[i] = xs();
        wr(`RCS_A_FIFO, {24'h0, exp_q[i]});
        crc = fold(crc, exp_q[i]);
        repeat (6) @(posedge clk_i);
        rdr(`RCS_A_CRC);
        chk("crc result", rd, {16'h0, crc});
      end
      wr(`RCS_A_CMD, 32'h10 | `RCS_OP_KEEP);
      rdr(`RCS_A_CMD);
      chk("code kept", rd[3:0], `RCS_OP_CRC);
      chk("sleep set", sleep_o, 1'b1);
      wr(`RCS_A_CMD, `RCS_OP_IDLE);
      rdr(`RCS_A_CMD);
      chk("crc cancelled", rd[3:0], `RCS_OP_IDLE);
    end
    test_end("crc");
    wr(`RCS_A_SELF, `RCS_SELF_ON);
    wr(`RCS_A_CMD, `RCS_OP_CRC);
    wait_idle();
    rdr(`RCS_A_LEVEL);
    chk("self test bytes", rd, `RCS_TEST_LEN);
    crc = preset(3);
    for (int i = 0; i < `RCS_TEST_LEN; i++) begin
      rdr(`RCS_A_FIFO);
      chk("self test byte", rd, {24'h0, crc[7:0]});
      crc = fold(crc, 8'(i));
    end
    wr(`RCS_A_SELF, 32'h0);
    test_end("self test");
    // transmit, transceive, receive and authentication
    for (int i = 0; i < `RCS_AUTH_LEN; i++) exp_q[i] = xs();
    for (int i = 0; i < 5; i++) wr(`RCS_A_FIFO, {24'h0, exp_q[i]});
    wr(`RCS_A_CMD, `RCS_OP_TX);
    wait_idle();
    chk("tx count", i_far.got.size(), 32'd5);
    for (int i = 0; i < 5; i++) chk("tx byte", i_far.got[i], exp_q[i]);
    i_far.got.delete();
    for (int i = 0; i < 4; i++) wr(`RCS_A_FIFO, {24'h0, exp_q[i]});
    wr(`RCS_A_CMD, `RCS_OP_TRX);
    repeat (30) @(posedge clk_i);
    chk("no send before launch", i_far.got.size(), 32'd0);
    wr(`RCS_A_FRAME, 32'h1 << `RCS_LAUNCH_POS);
    repeat (120) @(posedge clk_i);
    chk("trx tx count", i_far.got.size(), 32'd4);
    chk("tx starts", n_txs, 32'd2);
    rdr(`RCS_A_CMD);
    chk("trx repeats", rd[3:0], `RCS_OP_TRX);
    wr(`RCS_A_CMD, `RCS_OP_IDLE);
    drain_rx();
    wr(`RCS_A_CMD, `RCS_OP_RX);
    wait_idle();
    drain_rx();
    i_far.got.delete();
    i_far.n_auth = 0;
    for (int i = 0; i < `RCS_AUTH_LEN; i++) wr(`RCS_A_FIFO, {24'h0, exp_q[i]});
    wr(`RCS_A_CMD, `RCS_OP_AUTH);
    wait_idle();
    chk("auth bytes", i_far.n_auth, `RCS_AUTH_LEN);
    wr(`RCS_A_CMD, 32'hd);
    rdr(`RCS_A_CMD);
    chk("reserved code", rd[3:0], `RCS_OP_IDLE);
    test_end("link");
    print_verdict();
  end
endmodule
